// ---- core/cef_pkg.sv ----
package cef_pkg;

	// APB register byte addresses
	localparam logic [11:0] CEF_ADDR_CTRL = 12'h000;
	localparam logic [11:0] CEF_ADDR_SNAP = 12'h004;
	localparam logic [11:0] CEF_ADDR_STAT = 12'h008;

	// Register fields and reset values
	localparam int CEF_CTRL_EN_BIT = 0;
	localparam int CEF_STAT_BUSY_BIT = 0;
	localparam int CEF_STAT_CNT_LSB = 16;
	localparam logic CEF_EN_RESET = 1'b0;
	localparam logic [15:0] CEF_SNAP_RESET = 16'h0040;

	// Record layout
	localparam logic [6:0] CEF_TYPE_CODE = 7'h10;
	localparam logic [15:0] CEF_GEN_HDR_BYTES = 16'h0010;
	localparam logic [15:0] CEF_OFFPAD_BYTES = 16'h0002;
	localparam logic [15:0] CEF_REC_HDR_BYTES = 16'h0012;
	localparam logic [15:0] CEF_EXT_BYTES = 16'h0008;
	localparam logic [15:0] CEF_POS_TYPE = 16'h0008;
	localparam logic [15:0] CEF_POS_COLOR_HI = 16'h000C;
	localparam logic [15:0] CEF_POS_COLOR_LO = 16'h000D;
	localparam logic [15:0] CEF_L3_OFFSET = 16'h000E;
	localparam logic [3:0] CEF_HDR_LAST = 4'hF;
	localparam logic [2:0] CEF_EXT_LAST = 3'h7;

	typedef struct packed {
		logic [63:0] ts;
		logic [7:0] flags;
		logic [15:0] wlen;
		logic [5:0] stream;
		logic [7:0] filt_hit;
		logic [7:0] filt_present;
		logic hash_crc_bit;
		logic hash_parity_bit;
		logic [2:0] ext_n;
	} cef_desc_t;

	typedef struct packed {
		logic hash_parity_bit;
		logic hash_crc_bit;
		logic [7:0] filt_match;
		logic [5:0] stream;
	} cef_color_t;

	typedef enum logic [2:0] {
		CEF_IDLE,
		CEF_HDR,
		CEF_EXT,
		CEF_OFFPAD,
		CEF_PAY,
		CEF_FLUSH
	} cef_state_t;

endpackage

// ---- core/cef_color_tag.sv ----
`timescale 1ns/1ns
`default_nettype none
module cef_color_tag
	import cef_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire cef_desc_t desc,
	output cef_color_t color
);

	cef_color_t color_q;
	cef_color_t color_d;

	always_comb begin
		color_d.stream = desc.stream;
		color_d.filt_match = desc.filt_hit & desc.filt_present;
		color_d.hash_crc_bit = desc.hash_crc_bit;
		color_d.hash_parity_bit = desc.hash_parity_bit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			color_q <= '0;
		end else if (load) begin
			color_q <= color_d;
		end
	end

	assign color = color_q;

	AST_COLOR_STREAM: assert property (@(posedge pclk) disable iff (!presetn)
		load |=> color[5:0] == $past(desc.stream))
		else $error("color stream number wrong");
	AST_COLOR_FILT: assert property (@(posedge pclk) disable iff (!presetn)
		load |=> color[13:6] == ($past(desc.filt_hit) & $past(desc.filt_present)))
		else $error("color filter bits wrong");
	AST_COLOR_HASH: assert property (@(posedge pclk) disable iff (!presetn)
		load |=> color[14] == $past(desc.hash_crc_bit) && color[15] == $past(desc.hash_parity_bit))
		else $error("color hash bits wrong");

endmodule // cef_color_tag
`default_nettype wire

// ---- core/cef_record_framer.sv ----
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cef_record_framer
	import cef_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic desc_valid,
	input wire cef_desc_t desc,
	output logic desc_ready,
	input wire logic [63:0] ext_word,
	output logic ext_take,
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic in_ready,
	output logic out_valid,
	output logic [7:0] out_data,
	output logic out_last,
	input wire logic out_ready
);

	// APB slave
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q, en_q;
	logic [15:0] snap_q, rec_cnt_q;
	cef_state_t state_q, state_d;

	wire setup = psel && !penable;
	wire wr_take = psel && penable && pwrite && pready_q;
	wire hit_ctrl = paddr == CEF_ADDR_CTRL;
	wire hit_snap = paddr == CEF_ADDR_SNAP;
	wire hit_stat = paddr == CEF_ADDR_STAT;
	wire addr_ok = hit_ctrl || hit_snap || hit_stat;
	wire [31:0] stat_word = {rec_cnt_q, 15'h0000, state_q != CEF_IDLE};
	wire [31:0] rd_word = hit_ctrl ? {31'h0000_0000, en_q} :
		hit_snap ? {16'h0000, snap_q} :
		hit_stat ? stat_word : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup && !addr_ok;
			if (setup) begin
				prdata_q <= rd_word;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_q <= CEF_EN_RESET;
			snap_q <= CEF_SNAP_RESET;
		end else if (wr_take) begin
			if (hit_ctrl) begin
				en_q <= pwdata[CEF_CTRL_EN_BIT];
			end
			if (hit_snap) begin
				snap_q <= pwdata[15:0];
			end
		end
	end

	// Record sequencing
	logic desc_ready_q, ext_take_q, in_ready_q, seen_last_q;
	logic out_valid_q, out_last_q;
	logic [7:0] out_data_q;
	logic [15:0] pos_q, out_pos_q, rlen_q, cap_q, wlen_q, avail_q;
	logic [127:0] hdr_q;
	logic [2:0] ext_n_q, ext_k_q, ext_b_q;
	cef_color_t color;

	wire desc_take = desc_valid && desc_ready_q;
	wire in_take = in_valid && in_ready_q;
	wire out_free = !out_valid_q || out_ready;
	wire [15:0] ext_len_d = {10'h000, desc.ext_n, 3'b000};
	wire [15:0] need_d = CEF_REC_HDR_BYTES + ext_len_d;
	wire [15:0] avail_d = (snap_q > CEF_OFFPAD_BYTES) ? snap_q - CEF_OFFPAD_BYTES : 16'h0000;
	wire [15:0] cap_d = (desc.wlen < avail_d) ? desc.wlen : avail_d;
	wire [15:0] rlen_d = need_d + cap_d;
	wire [15:0] ext_len_q = {10'h000, ext_n_q, 3'b000};
	wire [15:0] pad_pos = CEF_GEN_HDR_BYTES + ext_len_q + 16'h0001;
	wire [15:0] off_pos = CEF_GEN_HDR_BYTES + ext_len_q;
	wire ext_more = (ext_k_q + 3'h1) != ext_n_q;
	wire [63:0] ext_mod = {ext_more, ext_word[62:0]};
	wire [7:0] type_byte = {desc.ext_n != 3'h0, CEF_TYPE_CODE};
	wire is_last = pos_q == rlen_q - 16'h0001;
	wire pay_load = (state_q == CEF_PAY) && out_free && (in_take || seen_last_q);
	// One idle cycle so the next extension word can be presented
	wire ext_wait = (state_q == CEF_EXT) && ext_take_q;
	wire hdr_load = (state_q == CEF_HDR || state_q == CEF_EXT || state_q == CEF_OFFPAD) && out_free && !ext_wait;
	wire load = hdr_load || pay_load;
	wire seen_last_d = (state_d == CEF_PAY) && (seen_last_q || (in_take && in_last));

	cef_color_tag u_color (
		.pclk(pclk),
		.presetn(presetn),
		.load(desc_take),
		.desc(desc),
		.color(color)
	);

	logic [7:0] byte_d;
	always_comb begin
		byte_d = 8'h00;
		unique case (state_q)
			CEF_HDR: byte_d = (pos_q[3:0] == CEF_POS_COLOR_HI[3:0]) ? color[15:8] :
				(pos_q[3:0] == CEF_POS_COLOR_LO[3:0]) ? color[7:0] : hdr_q[127:120];
			CEF_EXT: byte_d = ext_mod[{~ext_b_q, 3'b000} +: 8];
			CEF_PAY: byte_d = seen_last_q ? 8'h00 : in_data;
			CEF_IDLE, CEF_OFFPAD, CEF_FLUSH: byte_d = 8'h00;
		endcase
	end

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			CEF_IDLE: if (desc_take) begin
				state_d = CEF_HDR;
			end
			CEF_HDR: if (load && pos_q[3:0] == CEF_HDR_LAST) begin
				state_d = (ext_n_q != 3'h0) ? CEF_EXT : CEF_OFFPAD;
			end
			CEF_EXT: if (load && ext_b_q == CEF_EXT_LAST && !ext_more) begin
				state_d = CEF_OFFPAD;
			end
			CEF_OFFPAD: if (load && pos_q == pad_pos) begin
				state_d = (cap_q != 16'h0000) ? CEF_PAY : CEF_FLUSH;
			end
			CEF_PAY: if (load && is_last) begin
				state_d = (seen_last_q || (in_take && in_last)) ? CEF_IDLE : CEF_FLUSH;
			end
			CEF_FLUSH: if (in_take && in_last) begin
				state_d = CEF_IDLE;
			end
		endcase
	end

	wire in_ready_d = ((state_d == CEF_PAY) && !seen_last_d && !in_take && !(out_valid_q && !out_ready) && !load) ||
		((state_d == CEF_FLUSH) && !(in_take && in_last));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= CEF_IDLE;
			desc_ready_q <= 1'b0;
			in_ready_q <= 1'b0;
			seen_last_q <= 1'b0;
		end else begin
			state_q <= state_d;
			desc_ready_q <= (state_d == CEF_IDLE) && en_q && !desc_take;
			in_ready_q <= in_ready_d;
			seen_last_q <= seen_last_d;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr_q <= '0;
			{pos_q, rlen_q, cap_q, wlen_q, avail_q} <= '0;
			{ext_n_q, ext_k_q, ext_b_q} <= '0;
		end else if (desc_take) begin
			hdr_q <= {desc.ts, type_byte, desc.flags, rlen_d, 16'h0000, desc.wlen};
			{pos_q, rlen_q, cap_q, wlen_q, avail_q} <= {16'h0000, rlen_d, cap_d, desc.wlen, avail_d};
			{ext_n_q, ext_k_q, ext_b_q} <= {desc.ext_n, 3'h0, 3'h0};
		end else if (load) begin
			pos_q <= pos_q + 16'h0001;
			hdr_q <= {hdr_q[119:0], 8'h00};
			if (state_q == CEF_EXT) begin
				ext_b_q <= ext_b_q + 3'h1;
				ext_k_q <= ext_k_q + {2'b00, ext_b_q == CEF_EXT_LAST};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid_q <= 1'b0;
			out_data_q <= 8'h00;
			out_last_q <= 1'b0;
			out_pos_q <= 16'h0000;
			ext_take_q <= 1'b0;
			rec_cnt_q <= 16'h0000;
		end else begin
			ext_take_q <= load && state_q == CEF_EXT && ext_b_q == CEF_EXT_LAST;
			if (load) begin
				out_valid_q <= 1'b1;
				out_data_q <= byte_d;
				out_last_q <= is_last;
				out_pos_q <= pos_q;
				rec_cnt_q <= rec_cnt_q + {15'h0000, is_last};
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
			end
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign desc_ready = desc_ready_q;
	assign ext_take = ext_take_q;
	assign in_ready = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;
	assign out_last = out_last_q;

	AST_TYPE_CODE: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_pos_q == CEF_POS_TYPE |-> out_data_q[6:0] == CEF_TYPE_CODE)
		else $error("record code not 16");
	AST_TYPE_EXT: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_pos_q == CEF_POS_TYPE |-> out_data_q[7] == (ext_n_q != 3'h0))
		else $error("extension flag wrong");
	AST_COLOR_BYTES: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_pos_q == CEF_POS_COLOR_HI |-> out_data_q == color[15:8])
		else $error("color high byte wrong");
	AST_COLOR_LO: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_pos_q == CEF_POS_COLOR_LO |-> out_data_q == color[7:0])
		else $error("color low byte wrong");
	AST_OFFSET_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_pos_q == off_pos && state_q != CEF_IDLE |-> out_data_q == 8'h00)
		else $error("offset byte not zero");
	AST_L3_ALIGN: assert property (@(posedge pclk) disable iff (!presetn)
		load && state_q == CEF_PAY && pos_q == pad_pos + 16'h0001 |-> ((pos_q + CEF_L3_OFFSET) & 16'h0003) == 16'h0000)
		else $error("layer-3 header misaligned");
	AST_PAYLOAD_LEN: assert property (@(posedge pclk) disable iff (!presetn)
		state_q != CEF_IDLE |-> cap_q == rlen_q - CEF_GEN_HDR_BYTES - ext_len_q - CEF_OFFPAD_BYTES)
		else $error("payload length mismatch");
	AST_SNAP_SHORT: assert property (@(posedge pclk) disable iff (!presetn)
		desc_take && desc.wlen >= avail_d && avail_d != 16'h0000 |=> cap_q == $past(snap_q) - CEF_OFFPAD_BYTES)
		else $error("record not snap length");
	AST_EXT_CHAIN: assert property (@(posedge pclk) disable iff (!presetn)
		load && state_q == CEF_EXT && ext_b_q == 3'h0 |=> out_data_q[7] == $past(ext_more))
		else $error("extension chain bit wrong");
	AST_LAST_POS: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_last_q && state_q != CEF_HDR |-> out_pos_q == rlen_q - 16'h0001)
		else $error("last byte at wrong position");

	// Stream, sequencing and snap register checks
	AST_EXT_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
		ext_wait |-> !load)
		else $error("extension byte sent before next word");
	AST_PAD_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && out_pos_q == pad_pos && state_q != CEF_HDR |-> out_data_q == 8'h00)
		else $error("pad byte not zero");
	AST_OUT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
		out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q) && $stable(out_last_q))
		else $error("record byte changed while stalled");
	AST_IN_TAKE: assert property (@(posedge pclk) disable iff (!presetn)
		in_take && state_q == CEF_PAY |-> pay_load)
		else $error("payload byte taken but not emitted");
	AST_COLOR_STABLE: assert property (@(posedge pclk) disable iff (!presetn)
		state_q != CEF_IDLE |=> $stable(color))
		else $error("color changed inside a record");
	AST_DESC_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
		desc_take |-> state_q == CEF_IDLE)
		else $error("descriptor taken while busy");
	AST_HDR_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		desc_take |=> state_q == CEF_HDR && pos_q == 16'h0000)
		else $error("record does not start at header byte 0");
	AST_PAY_DATA: assert property (@(posedge pclk) disable iff (!presetn)
		pay_load && !seen_last_q |=> out_data_q == $past(in_data))
		else $error("payload byte not passed through");
	AST_SEEN_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
		pay_load && seen_last_q |=> out_data_q == 8'h00)
		else $error("fill byte after short frame not zero");
	AST_SNAP_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
		wr_take && hit_snap |=> snap_q == $past(pwdata[15:0]))
		else $error("snap length write lost");
	AST_FLUSH_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == CEF_FLUSH |-> !load)
		else $error("byte emitted while draining");
	AST_CAP_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
		state_q != CEF_IDLE |-> cap_q <= wlen_q && cap_q <= avail_q)
		else $error("captured length exceeds limit");

endmodule // cef_record_framer
`default_nettype wire

// ---- testbench/cef_host_sink.sv ----
`timescale 1ns/1ns
`default_nettype none
module cef_host_sink (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic out_valid,
	input wire logic [7:0] out_data,
	input wire logic out_last,
	output logic out_ready
);
	logic [7:0] rec_mem [0:255];
	int n_bytes;
	int rec_len;
	int n_recs;
	// Alternate stalls in slow mode; offset byte is stored, never read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_ready <= 1'b0;
			n_bytes <= 0;
			rec_len <= 0;
			n_recs <= 0;
		end else begin
			out_ready <= slow ? !out_ready : 1'b1;
			if (out_valid && out_ready) begin
				rec_mem[n_bytes[7:0]] <= out_data;
				n_bytes <= out_last ? 0 : n_bytes + 1;
				if (out_last) begin
					rec_len <= n_bytes + 1;
					n_recs <= n_recs + 1;
				end
			end
		end
	end
endmodule // cef_host_sink
`default_nettype wire

// ---- testbench/tb_cef_record_framer.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_cef_record_framer;
	import cef_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic pready, pslverr, desc_ready, ext_take, in_ready, out_valid, out_last, out_ready, err;
	logic desc_valid = 1'b0, in_valid = 1'b0, in_last = 1'b0, slow = 1'b0;
	cef_desc_t desc = '0;
	logic [63:0] ext_word = 64'h0000_0000_0000_0000;
	logic [7:0] in_data = 8'h00, out_data;
	int errors = 0;
	int n_compared = 0;
	always #25 pclk = ~pclk;
	cef_record_framer u_cef_record_framer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.desc_valid(desc_valid), .desc(desc), .desc_ready(desc_ready), .ext_word(ext_word), .ext_take(ext_take),
		.in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready));
	cef_host_sink u_cef_host_sink (.pclk(pclk), .presetn(presetn), .slow(slow), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready));
	task automatic tally_and_finish;
		if (errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic give_up;
		errors++;
		$display("[ERR] %0t wait ran out", $time);
		tally_and_finish();
	endtask
	task automatic chk_w(input logic [31:0] act, input logic [31:0] exp);
		n_compared++;
		if (act !== exp) begin
			errors++;
			$display("[ERR] %0t word %h expected %h", $time, act, exp);
		end
	endtask
	task automatic chk_b(input logic [7:0] act, input logic [7:0] exp);
		n_compared++;
		if (act !== exp) begin
			errors++;
			$display("[ERR] %0t byte %h expected %h", $time, act, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) give_up();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run_rec(input cef_desc_t d, input logic [63:0] e0, input logic [63:0] e1, input int flen,
		input int snap, input logic sl);
		int i, k, cap, rl, r0;
		logic [63:0] e;
		logic [15:0] c;
		cap = (d.wlen < snap - 2) ? d.wlen : snap - 2;
		rl = 18 + 8 * d.ext_n + cap;
		r0 = u_cef_host_sink.n_recs;
		@(posedge pclk);
		slow <= sl;
		ext_word <= e0;
		desc <= d;
		desc_valid <= 1'b1;
		fork
			begin
				int j;
				for (j = 0; j < 200; j++) begin
					@(posedge pclk);
					if (desc_ready === 1'b1) break;
				end
				desc_valid <= 1'b0;
				if (j == 200) give_up();
			end
			begin
				int j;
				int n;
				n = 0;
				in_valid <= 1'b1;
				in_data <= 8'h01;
				in_last <= (flen == 1);
				for (j = 0; j < 3000 && n < flen; j++) begin
					@(posedge pclk);
					if (in_ready === 1'b1) begin
						n++;
						in_data <= 8'(n + 1);
						in_last <= (n == flen - 1);
						if (n == flen) in_valid <= 1'b0;
					end
				end
				if (j == 3000) give_up();
			end
			begin
				int j;
				for (j = 0; j < 3000 && u_cef_host_sink.n_recs == r0; j++) begin
					@(posedge pclk);
					if (ext_take === 1'b1) ext_word <= e1;
				end
				if (j == 3000) give_up();
			end
		join
		chk_w(u_cef_host_sink.rec_len, rl);
		for (i = 0; i < 8; i++) chk_b(u_cef_host_sink.rec_mem[i], d.ts[63 - 8 * i -: 8]);
		chk_b(u_cef_host_sink.rec_mem[8], {d.ext_n != 3'd0, CEF_TYPE_CODE});
		chk_b(u_cef_host_sink.rec_mem[9], d.flags);
		chk_b(u_cef_host_sink.rec_mem[10], rl[15:8]);
		chk_b(u_cef_host_sink.rec_mem[11], rl[7:0]);
		c = {d.hash_parity_bit, d.hash_crc_bit, d.filt_hit & d.filt_present, d.stream};
		chk_b(u_cef_host_sink.rec_mem[12], c[15:8]);
		chk_b(u_cef_host_sink.rec_mem[13], c[7:0]);
		chk_b(u_cef_host_sink.rec_mem[14], d.wlen[15:8]);
		chk_b(u_cef_host_sink.rec_mem[15], d.wlen[7:0]);
		for (k = 0; k < d.ext_n; k++) begin
			e = (k == 0) ? e0 : e1;
			e[63] = (k < d.ext_n - 1);
			for (i = 0; i < 8; i++) chk_b(u_cef_host_sink.rec_mem[16 + 8 * k + i], e[63 - 8 * i -: 8]);
		end
		chk_b(u_cef_host_sink.rec_mem[17 + 8 * d.ext_n], 8'h00);
		for (i = 0; i < cap; i++)
			chk_b(u_cef_host_sink.rec_mem[18 + 8 * d.ext_n + i], 8'((i < flen) ? i + 1 : 0));
	endtask
	task automatic sc_regs;
		apb(1'b0, CEF_ADDR_CTRL, 32'h0000_0000);
		chk_w(rd, 32'h0000_0000);
		chk_w({31'h0000_0000, err}, 32'h0000_0000);
		apb(1'b0, CEF_ADDR_SNAP, 32'h0000_0000);
		chk_w(rd, {16'h0000, CEF_SNAP_RESET});
		apb(1'b1, 12'h00C, 32'hFFFF_FFFF);
		chk_w({31'h0000_0000, err}, 32'h0000_0001);
		apb(1'b0, 12'h00C, 32'h0000_0000);
		chk_w({rd[31:1], err}, 32'h0000_0001);
		apb(1'b1, CEF_ADDR_CTRL, 32'h0000_0001);
		apb(1'b0, CEF_ADDR_CTRL, 32'h0000_0000);
		chk_w(rd, 32'h0000_0001);
	endtask
	task automatic sc_ext_short;
		cef_desc_t d;
		d = '0;
		d.ts = 64'h0102_0304_0506_0708;
		d.flags = 8'h5A;
		d.wlen = 16'h0018;
		d.stream = 6'h3F;
		d.filt_hit = 8'hA5;
		d.filt_present = 8'h0F;
		d.hash_crc_bit = 1'b1;
		d.ext_n = 3'd2;
		run_rec(d, 64'h8011_2233_4455_6677, 64'h7F88_99AA_BBCC_DDEE, 12, 64, 1'b1);
	endtask
	task automatic sc_trunc;
		cef_desc_t d;
		d = '0;
		d.ts = 64'hF0E1_D2C3_B4A5_9687;
		d.wlen = 16'h003C;
		d.filt_hit = 8'hFF;
		d.filt_present = 8'hFF;
		d.hash_parity_bit = 1'b1;
		apb(1'b1, CEF_ADDR_SNAP, 32'h0000_0030);
		apb(1'b0, CEF_ADDR_SNAP, 32'h0000_0000);
		chk_w(rd, 32'h0000_0030);
		run_rec(d, 64'h0, 64'h0, 60, 48, 1'b0);
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		sc_regs();
		sc_ext_short();
		sc_trunc();
		apb(1'b0, CEF_ADDR_STAT, 32'h0000_0000);
		chk_w(rd, 32'h0002_0000);
		tally_and_finish();
	end
endmodule // tb_cef_record_framer
`default_nettype wire
